// [verilog/dpm_pkg.sv]
// Package for the debug probe mode control block.
// Assumes a single 20 MHz clock and an APB register bus.
package dpm_pkg;

    // ==========================================================
    // Register map
    localparam logic [11:0] DPM_FEAT_OFFS   = 12'h120;  // Feature control
    localparam logic [11:0] DPM_STAT_OFFS   = 12'h124;  // Probe status
    localparam logic [11:0] DPM_FUSEM_OFFS  = 12'h128;  // Protected fuse mask
    localparam logic [7:0]  DPM_FEAT_RST    = 8'hff;
    localparam logic [7:0]  DPM_FEAT_ONES   = 8'hf8;    // Bits above 2 read one
    localparam logic [7:0]  DPM_FUSEM_RST   = 8'h03;    // Default clock fuses
    localparam int          DPM_BIT_FUSE    = 0;
    localparam int          DPM_BIT_LOW_POWER_SELECT    = 1;
    localparam int          DPM_BIT_EOFF    = 2;

    // ==========================================================
    // Timing
    localparam int          DPM_CLK_HZ      = 20_000_000;
    localparam int          DPM_ENUM_WAIT_S = 5;
    localparam int          DPM_ENUM_CYC    = DPM_ENUM_WAIT_S * DPM_CLK_HZ;
    localparam int          DPM_BOOT_MS     = 200;
    localparam int          DPM_BOOT_CYC    = DPM_BOOT_MS * (DPM_CLK_HZ / 1000);
    localparam int          DPM_BLINK_MS    = 50;
    localparam int          DPM_BLINK_CYC   = DPM_BLINK_MS * (DPM_CLK_HZ / 1000);
    // Half periods of the clock output in mclk cycles (20 MHz base)
    localparam logic [3:0]  DPM_HALF_1MHZ   = 4'ha;
    localparam logic [3:0]  DPM_HALF_8MHZ   = 4'h1;
    localparam logic [3:0]  DPM_HALF_16MHZ  = 4'h1;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {DPM_BOOT, DPM_WAIT_ENUM, DPM_RUN, DPM_SLEEP} dpm_state_e;

    typedef struct packed {
        logic       eoff_n;   // 1: normal, 0: extended off allowed
        logic       low_power_select_n;   // 1: default clock, 0: forced 1 MHz
        logic       fuse_prot;
    } dpm_feat_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] fuse_idx;
    } dpm_fuse_req_s;
endpackage

// [verilog/dpm_probe_ctrl.sv]
// Mode control of an on-board debug probe: feature register, sleep,
// clock output, UART gating, status LED and fuse-write filter.
// Assumes APB from a local controller and USB/target engines outside.
`timescale 1ns/10ps

module dpm_probe_ctrl
    import dpm_pkg::*;
#(
    parameter int ENUM_CYC = dpm_pkg::DPM_ENUM_CYC,
    parameter int BOOT_CYC = dpm_pkg::DPM_BOOT_CYC
)
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // USB side
    input  wire logic                    usb_enumerated,
    input  wire logic                    host_dtr,
    output logic      [1:0]              usb_func_en,
    // Supply sense: 1 for 5.0V, 0 for 3.3V
    input  wire logic                    supply_5v0,
    // Target engine activity and fuse requests
    input  wire logic                    tgt_activity,
    input  wire dpm_pkg::dpm_fuse_req_s  fuse_req,
    output logic                         fuse_accept,
    output logic                         fuse_reject,
    output logic                         tgt_prog_en,
    // Target UART pins
    input  wire logic                    uart_tx_int,
    output logic                         uart_txd,
    output logic                         uart_tx_oe,
    // Clock output and LED
    output logic                         clk_out,
    output logic                         led_on,
    output logic                         deep_sleep
);
    import dpm_pkg::*;

    // ==========================================================
    // Register bus
    logic [2:0]  feat_q, feat_d;
    logic [7:0]  fusem_q, fusem_d;
    logic [31:0] prdata_d;
    logic        pslverr_d;
    logic        wr_acc;
    dpm_state_e  st_q, st_d;
    dpm_feat_s   feat;

    // Match of a bus address against one register offset
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] offs);
        addr_hit = (a == offs);
    endfunction

    // Write strobe and field view of the feature bits
    assign wr_acc = psel && penable && pwrite;
    assign feat   = dpm_feat_s'(feat_q);

    // Next register values and read data
    always_comb
    begin
        feat_d    = feat_q;
        fusem_d   = fusem_q;
        prdata_d  = prdata;
        pslverr_d = 1'b0;
        // Writes land at the access edge; unused bits of the word drop away
        if (wr_acc && addr_hit(paddr, DPM_FEAT_OFFS))
            feat_d = pwdata[2:0];
        if (wr_acc && addr_hit(paddr, DPM_FUSEM_OFFS))
            fusem_d = pwdata[7:0];
        if (psel && !penable)
        begin
            prdata_d = 32'h0;
            if (addr_hit(paddr, DPM_FEAT_OFFS))
                prdata_d = {24'h0, DPM_FEAT_ONES | {5'h0, feat_q}};
            // Status word: sleep, programming usable, UART driven, enumerated
            else if (addr_hit(paddr, DPM_STAT_OFFS))
                prdata_d = {28'h0, deep_sleep, tgt_prog_en, uart_tx_oe, usb_enumerated};
            else if (addr_hit(paddr, DPM_FUSEM_OFFS))
                prdata_d = {24'h0, fusem_q};
        end
        if (psel && !penable && !addr_hit(paddr, DPM_FEAT_OFFS)
            && !addr_hit(paddr, DPM_STAT_OFFS) && !addr_hit(paddr, DPM_FUSEM_OFFS))
            pslverr_d = 1'b1;
        else if (psel && penable)
            pslverr_d = pslverr;
    end

    // Register flops; pready rises at the first edge out of reset and then
    // stays high, so every access phase lasts one cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            feat_q  <= DPM_FEAT_RST[2:0];
            fusem_q <= DPM_FUSEM_RST;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            feat_q  <= feat_d;
            fusem_q <= fusem_d;
            prdata  <= prdata_d;
            pslverr <= pslverr_d;
            pready  <= 1'b1;
        end
    end

    // ==========================================================
    // Power state: boot, wait for enumeration, run or sleep
    // Wide enough for the five second deadline at the full clock rate
    logic [26:0] tmr_q, tmr_d;

    // Boot timer runs on into the enumeration wait, so the sleep deadline
    // counts from power-up, not from the end of boot
    always_comb
    begin
        st_d  = st_q;
        tmr_d = tmr_q;
        case (st_q)
            DPM_BOOT:
            begin
                tmr_d = tmr_q + 27'h1;
                if (tmr_q >= 27'(BOOT_CYC - 1))
                    st_d = DPM_WAIT_ENUM;
            end
            DPM_WAIT_ENUM:
            begin
                tmr_d = tmr_q + 27'h1;
                // Enumeration, or extended off not chosen, lets the probe run
                if (usb_enumerated || feat.eoff_n)
                    st_d = DPM_RUN;
                else if (tmr_q >= 27'(ENUM_CYC - 1))
                    st_d = DPM_SLEEP;
            end
            DPM_RUN:     st_d = DPM_RUN;
            DPM_SLEEP:   st_d = DPM_SLEEP;
            default:     st_d = DPM_BOOT;
        endcase
    end

    // Power state flops
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q  <= DPM_BOOT;
            tmr_q <= 27'h0;
        end
        else
        begin
            st_q  <= st_d;
            tmr_q <= tmr_d;
        end
    end

    // ==========================================================
    // Clock output divider
    logic [3:0] div_q, div_d;
    logic [3:0] half;
    logic       clk_d;
    logic       sleeping;

    // Deep sleep is final until the next reset
    assign sleeping = (st_q == DPM_SLEEP);

    // Select half period from mode and supply; 8 and 16 MHz are no whole
    // division of the 20 MHz base, so both supplies take the fastest one
    // that the single clock can make
    always_comb
    begin
        if (!feat.low_power_select_n)
            half = DPM_HALF_1MHZ;
        else if (supply_5v0)
            half = DPM_HALF_16MHZ;
        else
            half = DPM_HALF_8MHZ;
        div_d = div_q + 4'h1;
        clk_d = clk_out;
        if (sleeping)
        begin
            div_d = 4'h0;
            clk_d = 1'b0;
        end
        else if (div_q >= half - 4'h1)
        begin
            div_d = 4'h0;
            clk_d = !clk_out;
        end
    end

    // Divider and clock output flops
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_q   <= 4'h0;
            clk_out <= 1'b0;
        end
        else
        begin
            div_q   <= div_d;
            clk_out <= clk_d;
        end
    end

    // ==========================================================
    // Functions, UART gating, fuse filter, LED
    logic [1:0]  func_d;
    logic        uoe_d, utx_d, prog_d, acc_d, rej_d, led_d;
    logic [20:0] blink_q, blink_d;

    // True when the mask protects this fuse; indices past the mask never are
    function automatic logic fuse_guarded(input logic [7:0] idx, input logic [7:0] mask);
        fuse_guarded = 1'b0;
        if (idx < 8'($bits(mask)))
            fuse_guarded = mask[idx[2:0]];
    endfunction

    // Next values of the mode outputs
    always_comb
    begin
        func_d = sleeping ? 2'b00 : 2'b11;
        uoe_d  = host_dtr && !sleeping;
        // The UART pin carries host data only while driven
        utx_d  = uoe_d ? uart_tx_int : 1'b0;
        prog_d = !sleeping && feat.low_power_select_n;
        acc_d  = 1'b0;
        rej_d  = 1'b0;
        if (fuse_req.valid && prog_d)
        begin
            if (feat.fuse_prot && fuse_guarded(fuse_req.fuse_idx, fusem_q))
                rej_d = 1'b1;
            else
                acc_d = 1'b1;
        end
        // With programming unusable every fuse request is turned away
        else if (fuse_req.valid)
            rej_d = 1'b1;
        // Blink counter runs free; the LED shows its first half while busy
        blink_d = blink_q + 21'h1;
        if (blink_q >= 21'(2 * DPM_BLINK_CYC - 1))
            blink_d = 21'h0;
        if (st_q == DPM_BOOT)
            led_d = 1'b1;
        else if (tgt_activity && prog_d)
            led_d = (blink_q < 21'(DPM_BLINK_CYC));
        else
            led_d = 1'b0;
    end

    // Mode output flops
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            usb_func_en <= 2'b00;
            uart_tx_oe  <= 1'b0;
            uart_txd    <= 1'b0;
            tgt_prog_en <= 1'b0;
            fuse_accept <= 1'b0;
            fuse_reject <= 1'b0;
            blink_q     <= 21'h0;
            led_on      <= 1'b0;
            deep_sleep  <= 1'b0;
        end
        else
        begin
            usb_func_en <= func_d;
            uart_tx_oe  <= uoe_d;
            uart_txd    <= utx_d;
            tgt_prog_en <= prog_d;
            fuse_accept <= acc_d;
            fuse_reject <= rej_d;
            blink_q     <= blink_d;
            led_on      <= led_d;
            deep_sleep  <= sleeping;
        end
    end
endmodule

// [bench/dpm_usb_host.sv]
// Host-side model: USB enumeration, DTR and serial data.
// Assumes the bench drives plug and dtr_req.
`timescale 1ns/10ps
module dpm_usb_host #(
    parameter int ENUM_AT = 50
)
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // Bench controls
    input  wire logic plug,
    input  wire logic dtr_req,
    // Toward the probe
    output logic      usb_enumerated,
    output logic      host_dtr,
    output logic      uart_tx_int
);
    int cnt;
    // Enumerates a fixed time after plug; serial data toggles while DTR is up
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            cnt            <= 0;
            usb_enumerated <= 1'b0;
            host_dtr       <= 1'b0;
            uart_tx_int    <= 1'b1;
        end
        else
        begin
            cnt            <= plug ? cnt + 1 : 0;
            usb_enumerated <= plug && cnt >= ENUM_AT;
            host_dtr       <= dtr_req;
            uart_tx_int    <= host_dtr ? !uart_tx_int : 1'b1;
        end
endmodule

// [bench/dpm_assertions.sv]
// Checker for the probe mode control block.
// Assumes binding onto dpm_probe_ctrl; sees its ports only.
`timescale 1ns/10ps
module dpm_chk
    import dpm_pkg::*;
(
    // Clock, reset, APB
    input wire logic                   mclk,
    input wire logic                   rst_b,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    // Host and fuse inputs, mode outputs
    input wire logic                   host_dtr,
    input wire logic [1:0]             usb_func_en,
    input wire dpm_pkg::dpm_fuse_req_s fuse_req,
    input wire logic                   fuse_accept,
    input wire logic                   fuse_reject,
    input wire logic                   tgt_prog_en,
    input wire logic                   uart_tx_oe,
    input wire logic                   clk_out,
    input wire logic                   deep_sleep
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Properties
    a_feat_upper: assert property (psel && penable && !pwrite && paddr == DPM_FEAT_OFFS
        |-> prdata[31:3] == 29'h1f) else $error("feature upper bits wrong");
    a_unmap_err: assert property (psel && penable && !(paddr inside {12'h120, 12'h124,
        12'h128}) |-> pslverr) else $error("unmapped access not flagged");
    a_dtr_gates: assert property (uart_tx_oe |-> $past(host_dtr))
        else $error("uart driven without dtr");
    a_sleep_quiet: assert property (deep_sleep |-> usb_func_en == 2'h0 && !uart_tx_oe
        && !clk_out && !tgt_prog_en) else $error("activity while sleeping");
    a_sleep_holds: assert property (deep_sleep |=> deep_sleep)
        else $error("sleep left without reset");
    a_fuse_answer: assert property (fuse_req.valid |=> fuse_accept != fuse_reject)
        else $error("fuse request without one answer");
    a_func_both: assert property ($past(rst_b) && !deep_sleep |-> usb_func_en == 2'h3)
        else $error("usb functions missing");
    a_low_power_select_prog: assert property (psel && penable && pwrite && paddr == DPM_FEAT_OFFS
        && !pwdata[1] |-> ##[1:3] !tgt_prog_en) else $error("programming kept in low power");
endmodule
bind dpm_probe_ctrl dpm_chk u_chk (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .host_dtr(host_dtr), .usb_func_en(usb_func_en), .fuse_req(fuse_req),
    .fuse_accept(fuse_accept), .fuse_reject(fuse_reject), .tgt_prog_en(tgt_prog_en),
    .uart_tx_oe(uart_tx_oe), .clk_out(clk_out), .deep_sleep(deep_sleep));

// [bench/tb.sv]
// Self-checking bench for the probe mode control block.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module tb;
    import dpm_pkg::*;
    logic          mclk, rst_b, psel, penable, pwrite, supply_5v0, tgt_activity, plug, dtr_req;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, v;
    logic          pready, pslverr, usb_enumerated, host_dtr, uart_tx_int, fuse_accept;
    logic          fuse_reject, tgt_prog_en, uart_txd, uart_tx_oe, clk_out, led_on, deep_sleep;
    logic [1:0]    usb_func_en;
    dpm_fuse_req_s fuse_req;
    logic [32:0]   rq[$];
    logic [1:0]    fq[$];
    int            mismatches, comparisons, cyc, n;
    dpm_probe_ctrl #(.ENUM_CYC(200), .BOOT_CYC(20)) uut (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .usb_enumerated(usb_enumerated), .host_dtr(host_dtr), .usb_func_en(usb_func_en),
        .supply_5v0(supply_5v0), .tgt_activity(tgt_activity), .fuse_req(fuse_req),
        .fuse_accept(fuse_accept), .fuse_reject(fuse_reject), .tgt_prog_en(tgt_prog_en),
        .uart_tx_int(uart_tx_int), .uart_txd(uart_txd), .uart_tx_oe(uart_tx_oe),
        .clk_out(clk_out), .led_on(led_on), .deep_sleep(deep_sleep));
    dpm_usb_host u_host (.mclk(mclk), .rst_b(rst_b), .plug(plug), .dtr_req(dtr_req),
        .usb_enumerated(usb_enumerated), .host_dtr(host_dtr), .uart_tx_int(uart_tx_int));
    // ==========================================================
    // Clock, timeout and result monitor
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = !mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_sim;
        end
        if (psel && penable && pready && !pwrite)
            chk("prdata", rq.pop_front(), {pslverr, prdata});
        if (fuse_accept || fuse_reject)
            chk("fuse", fq.pop_front(), {fuse_reject, fuse_accept});
    end
    // ==========================================================
    // Tasks
    task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
        comparisons++;
        if (s !== e)
        begin
            mismatches++;
            $display("FAIL %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never sets psel in the same step
        @(posedge mclk);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e, logic err);
        rq.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic fuse(logic [7:0] i, logic [1:0] e);
        fq.push_back(e);
        fuse_req <= '{1'b1, i};
        @(posedge mclk);
        fuse_req <= '{1'b0, i};
        repeat (2) @(posedge mclk);
    endtask
    task automatic half(logic [32:0] e);
        @(posedge clk_out);
        n = cyc;
        @(negedge clk_out);
        chk("clk_half", e, cyc - n);
    endtask
    task automatic do_reset(logic p);
        rst_b <= 1'b0;
        plug  <= p;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        {rst_b, psel, penable, pwrite, supply_5v0, tgt_activity, plug, dtr_req} = 8'h0;
        {paddr, pwdata, fuse_req} = '0;
        v = $urandom(21714);
        do_reset(1'b0);
        #1 chk("led_boot", 1, led_on);
        repeat (30) @(posedge mclk);
        chk("led_idle", 0, led_on);
        rd(DPM_FEAT_OFFS, 32'hff, 1'b0);
        rd(DPM_FUSEM_OFFS, 32'(DPM_FUSEM_RST), 1'b0);
        rd(DPM_STAT_OFFS, 32'h4, 1'b0);
        rd(12'h12c, 32'h0, 1'b1);
        repeat (4)
        begin
            v = $urandom;
            apb(1'b1, DPM_FEAT_OFFS, v);
            rd(DPM_FEAT_OFFS, {24'h0, 5'h1f, v[2:0]}, 1'b0);
        end
        apb(1'b1, DPM_FEAT_OFFS, 32'hff);
        fuse(8'h00, 2'b10);
        fuse(8'h05, 2'b01);
        apb(1'b1, DPM_FEAT_OFFS, 32'hfe);
        fuse(8'h00, 2'b01);
        apb(1'b1, DPM_FEAT_OFFS, 32'hfc);
        fuse(8'h05, 2'b10);
        half(33'(DPM_HALF_1MHZ));
        chk("low_power_select_func", {2'h3, 1'b0}, {usb_func_en, tgt_prog_en});
        apb(1'b1, DPM_FEAT_OFFS, 32'hff);
        for (int s = 0; s < 2; s++)
        begin
            supply_5v0 <= s[0];
            half(33'(s[0] ? DPM_HALF_16MHZ : DPM_HALF_8MHZ));
        end
        repeat (3) @(posedge mclk);
        chk("oe_off", 0, uart_tx_oe);
        dtr_req <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("oe_on", 1, uart_tx_oe);
        v[0] = uart_tx_int;
        @(posedge mclk);
        chk("txd", v[0], uart_txd);
        tgt_activity <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("led_act", 1, led_on);
        tgt_activity <= 1'b0;
        repeat (200) @(posedge mclk);
        chk("no_sleep", 0, deep_sleep);
        for (int p = 0; p < 2; p++)
        begin
            do_reset(p[0]);
            apb(1'b1, DPM_FEAT_OFFS, 32'h0);
            repeat (260) @(posedge mclk);
            chk("sleep", p[0] ? 4'h7 : 4'h8, {deep_sleep, usb_func_en, uart_tx_oe});
        end
        end_sim;
    end
endmodule
